// ===== ibc_bus_ctrl.sv
// i2c bus start/stop control: busy tracking, condition issue, control reset
// assumes an AHB-Lite master on hclk and open-drain scl/sda pads outside
`timescale 1ns/1ps
`include "ibc_map.svh"

module ibc_bus_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        ack_miss,
  output logic             irq
);
  import ibc_pkg::*;

  localparam logic [`IBC_CNT_W-1:0] HALF_LAST =
    `IBC_CNT_W'(`IBC_HALF_CYC - 1);

  ibc_state_t st_r;
  ibc_state_t st_nxt;

  logic                 scl_s;
  logic                 start_det;
  logic                 stop_det;
  logic                 acc;
  logic                 is_i2c;
  logic                 is_mst;
  logic                 bus_busy_flag_vis;
  logic                 wr_ctrl2;
  logic                 cmd_start;
  logic                 cmd_stop;
  logic                 can_start;
  logic                 can_stop;
  logic [`IBC_EV_W-1:0] ev;
  logic [31:0]          rd_mux;

  ibc_line_mon u_mon (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_s     (scl_s),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  assign acc    = hsel & htrans[1] & hready;
  assign is_i2c = st_r.mode[`IBC_MODE_I2C_BIT];
  assign is_mst = st_r.mode[`IBC_MODE_MST_BIT];
  // busy is masked in clocked synchronous format
  assign bus_busy_flag_vis = st_r.bus_busy_flag & is_i2c;

  // a write only issues when bit 6 is written as zero
  assign wr_ctrl2  = st_r.wr_pend & (st_r.wr_addr == `IBC_OFF_CTRL2)
                   & ~hwdata[`IBC_SCP_BIT];
  assign cmd_start = wr_ctrl2 & hwdata[`IBC_BUS_BUSY_FLAG_BIT];
  assign cmd_stop  = wr_ctrl2 & ~hwdata[`IBC_BUS_BUSY_FLAG_BIT];
  // issue needs master mode, i2c format, no reset and a quiet engine
  assign can_stop  = is_mst & is_i2c & ~st_r.crst
                   & (st_r.cond == IBC_IDLE);
  assign can_start = can_stop & ~st_r.stat[`IBC_EV_NACK];

  always_comb begin
    ev = '0;
    ev[`IBC_EV_START] = start_det;
    ev[`IBC_EV_STOP]  = stop_det;
    ev[`IBC_EV_NACK]  = ack_miss;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `IBC_OFF_CTRL2: begin
        rd_mux[`IBC_BUS_BUSY_FLAG_BIT] = bus_busy_flag_vis;
        rd_mux[`IBC_SCP_BIT]  = 1'b1;
        rd_mux[`IBC_CRST_BIT] = st_r.crst;
      end
      `IBC_OFF_MODE: rd_mux[1:0] = st_r.mode;
      `IBC_OFF_STAT: rd_mux[`IBC_EV_W-1:0] = st_r.stat;
      `IBC_OFF_MASK: rd_mux[`IBC_EV_W-1:0] = st_r.mask;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;

    // address phase capture; read data registered for the data phase
    st_nxt.wr_pend = acc & hwrite;
    st_nxt.wr_addr = haddr[7:0];
    if (acc && !hwrite) begin
      st_nxt.rdata = rd_mux;
    end

    // data phase of a write
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        `IBC_OFF_CTRL2: st_nxt.crst = hwdata[`IBC_CRST_BIT];
        `IBC_OFF_MODE:  st_nxt.mode = hwdata[1:0];
        `IBC_OFF_STAT:  st_nxt.stat = st_r.stat & ~hwdata[`IBC_EV_W-1:0];
        `IBC_OFF_MASK:  st_nxt.mask = hwdata[`IBC_EV_W-1:0];
        default: ;
      endcase
    end
    // a set in the same cycle beats the write-one clear
    st_nxt.stat = st_nxt.stat | ev;

    // busy tracks the line even during control reset
    if (start_det) begin
      st_nxt.bus_busy_flag = 1'b1;
    end else if (stop_det) begin
      st_nxt.bus_busy_flag = 1'b0;
    end

    // condition generator, half a bus period per step
    case (st_r.cond)
      IBC_IDLE: begin
        st_nxt.cnt = '0;
        if (cmd_start && can_start) begin
          st_nxt.cond = IBC_RS_SDA;
        end else if (cmd_stop && can_stop) begin
          st_nxt.cond = IBC_SP_SDA;
        end
      end
      IBC_RS_SDA,
      IBC_RS_SCL,
      IBC_ST_SDA,
      IBC_SP_SDA,
      IBC_SP_SCL: begin
        if (st_r.cnt == HALF_LAST) begin
          st_nxt.cnt = '0;
          case (st_r.cond)
            IBC_RS_SDA: st_nxt.cond = IBC_RS_SCL;
            IBC_RS_SCL: st_nxt.cond = IBC_ST_SDA;
            IBC_ST_SDA: begin
              st_nxt.cond     = IBC_IDLE;
              st_nxt.hold_scl = 1'b1;
            end
            IBC_SP_SDA: st_nxt.cond = IBC_SP_SCL;
            default: begin
              st_nxt.cond     = IBC_IDLE;
              st_nxt.hold_scl = 1'b0;
            end
          endcase
        end else begin
          st_nxt.cnt = st_r.cnt + `IBC_CNT_W'(1);
        end
      end
      default: begin
        st_nxt.cond = IBC_IDLE;
        st_nxt.cnt  = '0;
      end
    endcase

    // control reset abandons any condition and lets go of both lines
    if (st_r.crst) begin
      st_nxt.cond     = IBC_IDLE;
      st_nxt.cnt      = '0;
      st_nxt.hold_scl = 1'b0;
    end

    // pin drive follows the next step; oe_n low pulls the line low
    case (st_nxt.cond)
      IBC_RS_SDA: begin
        st_nxt.scl_oe_n = ~st_nxt.hold_scl;
        st_nxt.sda_oe_n = 1'b1;
      end
      IBC_RS_SCL: begin
        st_nxt.scl_oe_n = 1'b1;
        st_nxt.sda_oe_n = 1'b1;
      end
      IBC_ST_SDA,
      IBC_SP_SCL: begin
        st_nxt.scl_oe_n = 1'b1;
        st_nxt.sda_oe_n = 1'b0;
      end
      IBC_SP_SDA: begin
        st_nxt.scl_oe_n = 1'b0;
        st_nxt.sda_oe_n = 1'b0;
      end
      default: begin
        // after a start scl is parked low for the byte engine
        st_nxt.scl_oe_n = ~st_nxt.hold_scl;
        st_nxt.sda_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0000_0000,
                bus_busy_flag: 1'b0, crst: 1'b0, mode: `IBC_MODE_RST,
                stat: '0, mask: '0, hold_scl: 1'b0, cond: IBC_IDLE,
                cnt: '0, scl_oe_n: 1'b1, sda_oe_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata    = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe_n  = st_r.scl_oe_n;
  assign sda_oe_n  = st_r.sda_oe_n;
  assign irq       = |(st_r.stat & st_r.mask);

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence rd_ctrl2_s;
    acc && !hwrite && (haddr[7:0] == `IBC_OFF_CTRL2);
  endsequence

  sequence start_walk_s;
    (st_r.cond == IBC_RS_SDA) && st_r.sda_oe_n;
  endsequence

  sequence start_cmd_s;
    cmd_start && can_start;
  endsequence

  busy_read_a: assert property (
    rd_ctrl2_s |=> hrdata[`IBC_BUS_BUSY_FLAG_BIT] == $past(bus_busy_flag_vis))
    else $error("busy flag readback wrong");

  sync_fmt_a: assert property (
    (rd_ctrl2_s and !is_i2c) |=> !hrdata[`IBC_BUS_BUSY_FLAG_BIT])
    else $error("busy flag seen in synchronous format");

  start_sets_a: assert property (
    start_det |=> st_r.bus_busy_flag)
    else $error("start condition did not set busy");

  stop_clears_a: assert property (
    (stop_det && !start_det) |=> !st_r.bus_busy_flag)
    else $error("stop condition did not clear busy");

  start_issue_a: assert property (
    start_cmd_s |=> start_walk_s)
    else $error("start condition not issued");

  stop_issue_a: assert property (
    (cmd_stop && can_stop) |=> (st_r.cond == IBC_SP_SDA) && !st_r.sda_oe_n)
    else $error("stop condition not issued");

  slave_quiet_a: assert property (
    (!is_mst && st_r.cond == IBC_IDLE) |=> st_r.cond == IBC_IDLE)
    else $error("condition issued outside master mode");

  issue_off_a: assert property (
    rd_ctrl2_s |=> hrdata[`IBC_SCP_BIT] && hrdata[5:2] == 4'h0)
    else $error("issue-disable bit not read as one");

  crst_idle_a: assert property (
    st_r.crst |=> st_r.cond == IBC_IDLE && st_r.sda_oe_n && st_r.scl_oe_n)
    else $error("control reset left lines driven");

  nack_hold_a: assert property (
    (st_r.stat[`IBC_EV_NACK] && cmd_start && st_r.cond == IBC_IDLE)
    |=> st_r.cond != IBC_RS_SDA)
    else $error("start issued while no-ack flag set");

  // a step ends on its last count unless a control reset cuts it
  logic step_end;
  assign step_end = (st_r.cnt == HALF_LAST) & ~st_r.crst;

  first_half_a: assert property (
    (st_r.cond == IBC_RS_SDA && step_end)
    |=> st_r.cond == IBC_RS_SCL && st_r.scl_oe_n && st_r.sda_oe_n)
    else $error("start first step did not release scl");

  start_edge_a: assert property (
    (st_r.cond == IBC_RS_SCL && step_end)
    |=> st_r.cond == IBC_ST_SDA && st_r.scl_oe_n && !st_r.sda_oe_n)
    else $error("start did not pull sda with scl high");

  scl_park_a: assert property (
    (st_r.cond == IBC_ST_SDA && step_end)
    |=> st_r.cond == IBC_IDLE && st_r.hold_scl && !st_r.scl_oe_n)
    else $error("scl not parked low after start");

  rstart_hold_a: assert property (
    (cmd_start && can_start && st_r.hold_scl)
    |=> st_r.cond == IBC_RS_SDA && !st_r.scl_oe_n && st_r.sda_oe_n)
    else $error("repeated start did not keep scl low");

  stop_step_a: assert property (
    (st_r.cond == IBC_SP_SDA && step_end)
    |=> st_r.cond == IBC_SP_SCL && st_r.scl_oe_n && !st_r.sda_oe_n)
    else $error("stop did not release scl with sda low");

  stop_end_a: assert property (
    (st_r.cond == IBC_SP_SCL && step_end)
    |=> st_r.cond == IBC_IDLE && st_r.scl_oe_n && st_r.sda_oe_n)
    else $error("stop did not release sda");

  issue_mask_a: assert property (
    (st_r.wr_pend && st_r.wr_addr == `IBC_OFF_CTRL2
     && hwdata[`IBC_SCP_BIT] && st_r.cond == IBC_IDLE)
    |=> st_r.cond == IBC_IDLE)
    else $error("write with issue-disable set issued a condition");

  crst_store_a: assert property (
    (st_r.wr_pend && st_r.wr_addr == `IBC_OFF_CTRL2)
    |=> st_r.crst == $past(hwdata[`IBC_CRST_BIT]))
    else $error("control reset bit not stored");

  nack_set_a: assert property (
    ack_miss |=> st_r.stat[`IBC_EV_NACK])
    else $error("no-ack flag not set");

  start_flag_a: assert property (
    start_det |=> st_r.stat[`IBC_EV_START])
    else $error("start seen flag not set");

  crst_detect_a: assert property (
    (st_r.crst && start_det) |=> st_r.bus_busy_flag)
    else $error("detection stopped during control reset");

  cnt_range_a: assert property (
    st_r.cnt <= HALF_LAST)
    else $error("step counter past its last count");

endmodule : ibc_bus_ctrl

// ===== ibc_map.svh
// register map, field positions, reset values and timing counts
// assumes a 125 MHz hclk; included by ibc_pkg, ibc_bus_ctrl and the testbench
`ifndef IBC_MAP_SVH
`define IBC_MAP_SVH

`define IBC_OFF_CTRL2    8'h00
`define IBC_OFF_MODE     8'h04
`define IBC_OFF_STAT     8'h08
`define IBC_OFF_MASK     8'h0c

`define IBC_BUS_BUSY_FLAG_BIT     7
`define IBC_SCP_BIT      6
`define IBC_CRST_BIT     1

`define IBC_MODE_I2C_BIT 0
`define IBC_MODE_MST_BIT 1
`define IBC_MODE_RST     2'h1

`define IBC_EV_START     0
`define IBC_EV_STOP      1
`define IBC_EV_NACK      2
`define IBC_EV_W         3

`define IBC_T_HALF_NS    5000
`define IBC_CLK_MHZ      125
`define IBC_HALF_CYC     ((`IBC_T_HALF_NS * `IBC_CLK_MHZ + 999) / 1000)
`define IBC_CNT_W        10

`endif

// ===== ibc_pkg.sv
// types shared by the bus start/stop control block
// relies on ibc_map.svh for the widths
`include "ibc_map.svh"

package ibc_pkg;

  typedef enum logic [2:0] {
    IBC_IDLE,
    IBC_RS_SDA,
    IBC_RS_SCL,
    IBC_ST_SDA,
    IBC_SP_SDA,
    IBC_SP_SCL
  } ibc_cond_t;

  typedef struct packed {
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [31:0]           rdata;
    logic                  bus_busy_flag;
    logic                  crst;
    logic [1:0]            mode;
    logic [`IBC_EV_W-1:0]  stat;
    logic [`IBC_EV_W-1:0]  mask;
    logic                  hold_scl;
    ibc_cond_t             cond;
    logic [`IBC_CNT_W-1:0] cnt;
    logic                  scl_oe_n;
    logic                  sda_oe_n;
  } ibc_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic start;
    logic stop;
  } ibc_mon_t;

endpackage : ibc_pkg

// ===== ibc_line_mon.sv
// line monitor: synchronises scl/sda and flags start and stop conditions
// assumes scl_i/sda_i are raw pin levels, asynchronous to hclk
`timescale 1ns/1ps

module ibc_line_mon (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_s,
  output logic      start_det,
  output logic      stop_det
);
  import ibc_pkg::*;

  ibc_mon_t m_r;
  ibc_mon_t m_nxt;

  always_comb begin
    m_nxt       = m_r;
    m_nxt.scl_m = scl_i;
    m_nxt.scl_s = m_r.scl_m;
    m_nxt.scl_d = m_r.scl_s;
    m_nxt.sda_m = sda_i;
    m_nxt.sda_s = m_r.sda_m;
    m_nxt.sda_d = m_r.sda_s;
    // only the second stage and later are looked at
    m_nxt.start = m_r.scl_s & m_r.scl_d & m_r.sda_d & ~m_r.sda_s;
    m_nxt.stop  = m_r.scl_s & m_r.scl_d & ~m_r.sda_d & m_r.sda_s;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_r <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
               sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
               start: 1'b0, stop: 1'b0};
    end else begin
      m_r <= m_nxt;
    end
  end

  assign scl_s     = m_r.scl_s;
  assign start_det = m_r.start;
  assign stop_det  = m_r.stop;

endmodule : ibc_line_mon

// ===== ibc_i2c_peer.sv
// far-side i2c device: pull-ups on scl and sda, frames on request
// assumes the block's open-drain enables, low while it pulls a line
`timescale 1ns/1ps

module ibc_i2c_peer (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic scl_lo;
  logic sda_lo;

  // wired-and with pull-ups: a released line reads high
  assign scl = scl_oe_n & ~scl_lo;
  assign sda = sda_oe_n & ~sda_lo;

  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  // sda falls with scl high, then four 64 ns link clocks
  task automatic frame_open();
    sda_lo = 1'b1;
    #32;
    repeat (4) begin
      scl_lo = 1'b1;
      #32;
      scl_lo = 1'b0;
      #32;
    end
  endtask : frame_open

  // sda rises with scl high; scl stands still afterwards
  task automatic frame_close();
    #32;
    sda_lo = 1'b0;
    #64;
  endtask : frame_close
endmodule : ibc_i2c_peer

// ===== ibc_bus_ctrl_tb_top.sv
// testbench: ahb-lite register traffic and checks on the i2c lines
// assumes ibc_i2c_peer is the only other device on the bus
`timescale 1ns/1ps
`include "ibc_map.svh"

module ibc_bus_ctrl_tb_top;
  localparam logic [7:0] off_c2 = `IBC_OFF_CTRL2;
  localparam logic [7:0] off_md = `IBC_OFF_MODE;
  localparam logic [7:0] off_st = `IBC_OFF_STAT;
  localparam logic [7:0] off_mk = `IBC_OFF_MASK;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        ack_miss;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        scl;
  logic        sda;
  logic        irq;
  int          n_fail;
  int          comparisons;

  ibc_bus_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(), .sda_oe_n(sda_oe_n), .ack_miss(ack_miss), .irq(irq)
  );
  ibc_i2c_peer peer (
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_up();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask : give_up

  task automatic ready_wait();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (hreadyout !== 1'b1) give_up();
  endtask : ready_wait

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    ready_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ready_wait();
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rchk

  // bounded wait for one line to reach a level
  task automatic wait_line(input bit on_sda, input logic v);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge hclk);
      if ((on_sda ? sda : scl) === v) break;
    end
    if (i >= 4000) give_up();
  endtask : wait_line

  // longer than a whole condition: any pull counts as an issue
  task automatic quiet();
    logic drove;
    drove = 1'b0;
    repeat (2000) begin
      @(posedge hclk);
      if (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1) drove = 1'b1;
    end
    chk({31'h0, drove}, 32'h0);
  endtask : quiet

  initial begin
    n_fail = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ack_miss = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(off_c2, 32'h40);
    rchk(off_md, 32'h1);
    rchk(off_st, 32'h0);
    rchk(off_mk, 32'h0);
    rchk(8'h10, 32'h0);
    bus(1'b1, off_c2, 32'h80);
    quiet();
    bus(1'b1, off_mk, 32'h3);
    peer.frame_open();
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'hc0);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, off_st, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    peer.frame_close();
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'h40);
    chk({31'h0, irq}, 32'h1);
    rchk(off_st, 32'h2);
    bus(1'b1, off_mk, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, off_md, 32'h0);
    peer.frame_open();
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'h40);
    peer.frame_close();
    bus(1'b1, off_md, 32'h3);
    bus(1'b1, off_st, 32'h7);
    bus(1'b1, off_c2, 32'hc0);
    quiet();
    rchk(off_c2, 32'h40);
    @(posedge hclk);
    ack_miss <= 1'b1;
    @(posedge hclk);
    ack_miss <= 1'b0;
    rchk(off_st, 32'h4);
    bus(1'b1, off_c2, 32'h80);
    quiet();
    bus(1'b1, off_st, 32'h4);
    bus(1'b1, off_c2, 32'h80);
    wait_line(1'b1, 1'b0);
    chk({31'h0, scl}, 32'h1);
    wait_line(1'b0, 1'b0);
    rchk(off_c2, 32'hc0);
    bus(1'b1, off_c2, 32'h80);
    wait_line(1'b1, 1'b1);
    wait_line(1'b0, 1'b1);
    wait_line(1'b1, 1'b0);
    chk({31'h0, scl}, 32'h1);
    wait_line(1'b0, 1'b0);
    bus(1'b1, off_c2, 32'h0);
    wait_line(1'b0, 1'b1);
    chk({31'h0, sda}, 32'h0);
    wait_line(1'b1, 1'b1);
    chk({31'h0, scl}, 32'h1);
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'h40);
    bus(1'b1, off_c2, 32'h80);
    wait_line(1'b1, 1'b0);
    wait_line(1'b0, 1'b0);
    // hung-bus recovery: control reset while scl is parked low
    bus(1'b1, off_c2, 32'h42);
    repeat (8) @(posedge hclk);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    rchk(off_md, 32'h3);
    bus(1'b0, off_c2, 32'h0);
    chk(rd & 32'h7f, 32'h42);
    peer.frame_open();
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'hc2);
    peer.frame_close();
    repeat (8) @(posedge hclk);
    rchk(off_c2, 32'h42);
    bus(1'b1, off_c2, 32'h0);
    bus(1'b1, off_md, 32'h3);
    rchk(off_c2, 32'h40);
    tally_and_finish();
  end
endmodule : ibc_bus_ctrl_tb_top
